// ===== verilog/dss_scroller.sv
// dynamic station name scroller: register bank, sequencer and output buffer
`timescale 1ns/1ps

module dss_scroller
  import dss_pkg::*;
#(
  parameter int unsigned P_HOLD_UNIT_CYC   = dss_pkg::HOLD_UNIT_CYC,
  parameter int unsigned P_STATIC_UNIT_CYC = dss_pkg::STATIC_UNIT_CYC,
  parameter int unsigned P_FAST_STEP_CYC   = dss_pkg::FAST_STEP_CYC,
  parameter int unsigned P_SLOW_STEP_CYC   = dss_pkg::SLOW_STEP_CYC
)(
  // clock and reset
  input  wire logic            i_mclk,
  input  wire logic            i_rst,
  // configuration bus byte port
  input  wire dss_pkg::dss_bus_t i_bus,
  output logic [7:0]           o_rdata,
  // segment stream to the group assembler
  output logic                 o_seg_valid,
  output dss_pkg::dss_seg_t    o_seg,
  input  wire logic            i_seg_ready,
  // status
  output logic                 o_loop_running,
  output logic                 o_name_pending
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (P_HOLD_UNIT_CYC == 0 || P_STATIC_UNIT_CYC == 0 ||
      P_FAST_STEP_CYC == 0 || P_SLOW_STEP_CYC == 0)
  begin : g_bad_param
    $error("dss_scroller: timing counts must be nonzero");
  end

  dss_regs_t r_q;
  dss_regs_t r_d;

  // ----------------------------------------------------------------
  // text fetch: blank beyond the length or the store
  // ----------------------------------------------------------------
  function automatic logic [7:0] fetch(input logic [TEXT_MAX-1:0][7:0] t,
                                       input logic [7:0] n,
                                       input logic [8:0] idx);
    logic [7:0] c;
    c = SPACE_CHAR;
    if (idx < 9'(n) && idx < 9'(TEXT_MAX))
    begin
      c = t[7'(idx)];
    end
    return c;
  endfunction : fetch

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [7:0][7:0] seg_chars;
  logic [7:0]      take;
  logic [8:0]      nxt;
  logic            dyn_done;
  logic [39:0]     step_cyc;
  logic            push;
  dss_seg_t        push_seg;
  logic [7:0]      a;

  always_comb
  begin
    r_d       = r_q;
    seg_chars = '0;
    take      = 8'(NAME_LEN);
    nxt       = '0;
    dyn_done  = 1'b0;
    step_cyc  = '0;
    push      = 1'b0;
    push_seg  = '0;
    a         = i_bus.addr;

    // window of the current dynamic segment, first char in chars[7]
    for (int i = 0; i < NAME_LEN; i++)
    begin
      if (r_q.style == STYLE_PAD_SHIFT)
      begin
        if (9'(r_q.pos) + 9'(i) >= 9'(NAME_LEN))
          seg_chars[7-i] = fetch(r_q.text, r_q.text_len,
                                 9'(r_q.pos) + 9'(i) - 9'(NAME_LEN));
        else
          seg_chars[7-i] = SPACE_CHAR;
      end
      else
      begin
        seg_chars[7-i] = fetch(r_q.text, r_q.text_len, 9'(r_q.pos) + 9'(i));
      end
    end
    // word style: cut at the last space if a word would be split
    if (r_q.style == STYLE_WORD &&
        fetch(r_q.text, r_q.text_len, 9'(r_q.pos) + 9'(NAME_LEN)) != SPACE_CHAR)
    begin
      for (int i = 1; i < NAME_LEN; i++)
      begin
        if (seg_chars[7-i] == SPACE_CHAR)
          take = 8'(i);
      end
      for (int i = 0; i < NAME_LEN; i++)
      begin
        if (8'(i) >= take)
          seg_chars[7-i] = SPACE_CHAR;
      end
    end

    // advance and end of loop per style
    case (r_q.style)
      STYLE_BLOCK:
      begin
        nxt      = 9'(r_q.pos) + 9'(NAME_LEN);
        dyn_done = nxt >= 9'(r_q.text_len);
        step_cyc = 40'(r_q.seg_hold) * 40'(P_HOLD_UNIT_CYC);
      end
      STYLE_WORD:
      begin
        nxt = 9'(r_q.pos) + 9'(take);
        if (fetch(r_q.text, r_q.text_len, nxt) == SPACE_CHAR)
          nxt = nxt + 9'h001;
        dyn_done = nxt >= 9'(r_q.text_len);
        step_cyc = 40'(r_q.seg_hold) * 40'(P_HOLD_UNIT_CYC);
      end
      STYLE_SHIFT:
      begin
        nxt      = 9'(r_q.pos) + 9'h001;
        dyn_done = nxt + 9'(NAME_LEN) > 9'(r_q.text_len);
        step_cyc = 40'(r_q.slow_rate ? P_SLOW_STEP_CYC : P_FAST_STEP_CYC);
      end
      default:
      begin
        nxt      = 9'(r_q.pos) + 9'h001;
        dyn_done = nxt >= 9'(r_q.text_len) + 9'(NAME_LEN);
        step_cyc = 40'(r_q.slow_rate ? P_SLOW_STEP_CYC : P_FAST_STEP_CYC);
      end
    endcase

    // sequencer
    case (r_q.state)
      ST_STATIC_SHOW:
      begin
        if (r_q.count != 2'h2)
        begin
          push = 1'b1;
          if (r_q.pending)
          begin
            r_d.name_act = r_q.name_buf;
            r_d.pending  = 1'b0;
          end
          push_seg.dynamic = 1'b0;
          push_seg.chars   = r_q.pending ? r_q.name_buf : r_q.name_act;
          r_d.reshow       = 1'b0;
          r_d.timer        = 40'(r_q.static_ivl) * 40'(P_STATIC_UNIT_CYC);
          r_d.state        = ST_STATIC_WAIT;
        end
      end
      ST_STATIC_WAIT:
      begin
        if (r_q.pending || r_q.reshow)
          r_d.state = ST_STATIC_SHOW;
        else if (r_q.timer > 40'h1)
          r_d.timer = r_q.timer - 40'h1;
        else if (r_q.text_len != 8'h00 &&
                 !(r_q.static_ivl == ONCE_IVL && r_q.once_done))
        begin
          r_d.pos   = (r_q.style == STYLE_PAD_SHIFT) ? 8'h01 : 8'h00;
          r_d.state = ST_DYN_SHOW;
        end
      end
      ST_DYN_SHOW:
      begin
        if (r_q.count != 2'h2)
        begin
          push = 1'b1;
          if (r_q.pending)
          begin
            r_d.name_act = r_q.name_buf;
            r_d.pending  = 1'b0;
          end
          push_seg.dynamic = 1'b1;
          push_seg.chars   = seg_chars;
          r_d.timer        = (step_cyc == 40'h0) ? 40'h1 : step_cyc;
          r_d.state        = ST_DYN_WAIT;
        end
      end
      ST_DYN_WAIT:
      begin
        if (r_q.timer > 40'h1)
          r_d.timer = r_q.timer - 40'h1;
        else if (dyn_done || r_q.text_len == 8'h00)
        begin
          r_d.once_done = 1'b1;
          r_d.state     = ST_STATIC_SHOW;
        end
        else
        begin
          r_d.pos   = nxt[7:0];
          r_d.state = ST_DYN_SHOW;
        end
      end
      default:
      begin
        r_d.state = ST_STATIC_SHOW;
      end
    endcase

    // register writes
    if (i_bus.wr)
    begin
      r_d.any_written = 1'b1;
      if (a == ADDR_STATIC_IVL)
        r_d.static_ivl = i_bus.wdata;
      else if (a == ADDR_DISPLAY_STYLE)
        r_d.style = i_bus.wdata[1:0];
      else if (a == ADDR_SEG_HOLD)
        r_d.seg_hold = i_bus.wdata;
      else if (a == ADDR_SCROLL_RATE)
        r_d.slow_rate = i_bus.wdata[0];
      else if (a == ADDR_TEXT_LEN)
      begin
        r_d.text_len  = (i_bus.wdata > 8'(TEXT_MAX)) ? 8'(TEXT_MAX) : i_bus.wdata;
        r_d.once_done = 1'b0;
        r_d.pos       = 8'h00;
        r_d.timer     = 40'h1;
        r_d.state     = ST_STATIC_WAIT;
      end
      else if (a >= ADDR_TEXT_FIRST && a <= ADDR_TEXT_LAST)
        r_d.text[7'(a - ADDR_TEXT_FIRST)] = i_bus.wdata;
      else if (a >= ADDR_NAME_ACT_LO && a <= ADDR_NAME_ACT_HI)
        r_d.name_act[3'(ADDR_NAME_ACT_HI - a)] = i_bus.wdata;
      else if (a >= ADDR_NAME_BUF_LO && a <= ADDR_NAME_BUF_HI)
      begin
        r_d.name_buf[3'(ADDR_NAME_BUF_HI - a)] = i_bus.wdata;
        r_d.buf_written = 1'b1;
      end
    end
    // stop: release buffered name, refresh static display
    if (i_bus.stop)
    begin
      // a write that meets the stop belongs to the next session
      r_d.buf_written = i_bus.wr && a >= ADDR_NAME_BUF_LO && a <= ADDR_NAME_BUF_HI;
      r_d.any_written = i_bus.wr;
      if (r_q.buf_written)
        r_d.pending = 1'b1;
      if (r_q.any_written)
        r_d.reshow = 1'b1;
    end

    // register reads, bit 7 is msb throughout
    if (i_bus.rd)
    begin
      r_d.rdata = REG_RESET;
      if (a == ADDR_STATUS)
      begin
        r_d.rdata[STAT_LOOP_BIT] = (r_q.state == ST_DYN_SHOW) ||
                                   (r_q.state == ST_DYN_WAIT);
        r_d.rdata[STAT_PEND_BIT] = r_q.pending;
      end
      else if (a == ADDR_STATIC_IVL)
        r_d.rdata = r_q.static_ivl;
      else if (a == ADDR_DISPLAY_STYLE)
        r_d.rdata = {6'h00, r_q.style};
      else if (a == ADDR_SEG_HOLD)
        r_d.rdata = r_q.seg_hold;
      else if (a == ADDR_SCROLL_RATE)
        r_d.rdata = {7'h00, r_q.slow_rate};
      else if (a == ADDR_TEXT_LEN)
        r_d.rdata = r_q.text_len;
      else if (a >= ADDR_TEXT_FIRST && a <= ADDR_TEXT_LAST)
        r_d.rdata = r_q.text[7'(a - ADDR_TEXT_FIRST)];
      else if (a >= ADDR_NAME_ACT_LO && a <= ADDR_NAME_ACT_HI)
        r_d.rdata = r_q.name_act[3'(ADDR_NAME_ACT_HI - a)];
      else if (a >= ADDR_NAME_BUF_LO && a <= ADDR_NAME_BUF_HI)
        r_d.rdata = r_q.name_buf[3'(ADDR_NAME_BUF_HI - a)];
    end

    // two-entry output buffer
    if (push)
    begin
      r_d.fifo[r_q.wr_ptr] = push_seg;
      r_d.wr_ptr           = ~r_q.wr_ptr;
    end
    if (o_seg_valid && i_seg_ready)
      r_d.rd_ptr = ~r_q.rd_ptr;
    r_d.count = r_q.count + 2'(push) - 2'(o_seg_valid && i_seg_ready);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      r_q <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rdata        = r_q.rdata;
  assign o_seg_valid    = r_q.count != 2'h0;
  assign o_seg          = dss_seg_t'(r_q.fifo[r_q.rd_ptr]);
  assign o_loop_running = (r_q.state == ST_DYN_SHOW) || (r_q.state == ST_DYN_WAIT);
  assign o_name_pending = r_q.pending;

endmodule : dss_scroller

// ===== shared/dss_pkg.sv
// package for the dynamic station name scroller: map, timing, carriers
package dss_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the configuration bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS        = 8'h70;
  localparam logic [7:0] ADDR_STATIC_IVL    = 8'h72;
  localparam logic [7:0] ADDR_DISPLAY_STYLE = 8'h73;
  localparam logic [7:0] ADDR_SEG_HOLD      = 8'h74;
  localparam logic [7:0] ADDR_SCROLL_RATE   = 8'h75;
  localparam logic [7:0] ADDR_TEXT_LEN      = 8'h76;
  localparam logic [7:0] ADDR_TEXT_FIRST    = 8'h77;
  localparam logic [7:0] ADDR_TEXT_LAST     = 8'hc6;
  localparam logic [7:0] ADDR_RESERVED      = 8'hc7;
  localparam logic [7:0] ADDR_NAME_ACT_LO   = 8'hc8;
  localparam logic [7:0] ADDR_NAME_ACT_HI   = 8'hcf;
  localparam logic [7:0] ADDR_NAME_BUF_LO   = 8'h10;
  localparam logic [7:0] ADDR_NAME_BUF_HI   = 8'h17;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int         STAT_LOOP_BIT   = 2;
  localparam int         STAT_PEND_BIT   = 3;
  localparam int         TEXT_MAX        = 80;
  localparam int         NAME_LEN        = 8;
  localparam logic [7:0] ONCE_IVL        = 8'hff;
  localparam logic [7:0] SPACE_CHAR      = 8'h20;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [1:0] STYLE_BLOCK     = 2'h0;
  localparam logic [1:0] STYLE_SHIFT     = 2'h1;
  localparam logic [1:0] STYLE_WORD      = 2'h2;
  localparam logic [1:0] STYLE_PAD_SHIFT = 2'h3;

  // ----------------------------------------------------------------
  // timing: units in ms, counts derived from the clock rate
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ        = 100_000;
  localparam int unsigned HOLD_UNIT_MS   = 540;
  localparam int unsigned STATIC_UNIT_MS = 2700;
  localparam int unsigned FAST_STEP_MS   = 300;
  localparam int unsigned SLOW_STEP_MS   = 1000;
  localparam int unsigned HOLD_UNIT_CYC   = CLK_KHZ * HOLD_UNIT_MS;
  localparam int unsigned STATIC_UNIT_CYC = CLK_KHZ * STATIC_UNIT_MS;
  localparam int unsigned FAST_STEP_CYC   = CLK_KHZ * FAST_STEP_MS;
  localparam int unsigned SLOW_STEP_CYC   = CLK_KHZ * SLOW_STEP_MS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_STATIC_SHOW,
    ST_STATIC_WAIT,
    ST_DYN_SHOW,
    ST_DYN_WAIT
  } dss_state_t;

  // chars[7] is the first displayed char, so it leaves first (high byte)
  typedef struct packed {
    logic            dynamic;
    logic [7:0][7:0] chars;
  } dss_seg_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       stop;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dss_bus_t;

  typedef struct packed {
    logic [7:0]                 static_ivl;
    logic [1:0]                 style;
    logic [7:0]                 seg_hold;
    logic                       slow_rate;
    logic [7:0]                 text_len;
    logic [TEXT_MAX-1:0][7:0]   text;
    logic [NAME_LEN-1:0][7:0]   name_buf;
    logic [NAME_LEN-1:0][7:0]   name_act;
    logic                       buf_written;
    logic                       any_written;
    logic                       pending;
    logic                       reshow;
    logic                       once_done;
    dss_state_t                 state;
    logic [7:0]                 pos;
    logic [39:0]                timer;
    logic [7:0]                 rdata;
    logic [1:0][$bits(dss_seg_t)-1:0] fifo;
    logic                       wr_ptr;
    logic                       rd_ptr;
    logic [1:0]                 count;
  } dss_regs_t;

endpackage : dss_pkg

// ===== tb/dss_scroller_assertions.sv
// checker: port-level assertions for the station name scroller
`timescale 1ns/1ps

module dss_scroller_assertions
  import dss_pkg::*;
#(
  parameter int unsigned P_HOLD_UNIT_CYC   = 4,
  parameter int unsigned P_STATIC_UNIT_CYC = 10,
  parameter int unsigned P_FAST_STEP_CYC   = 3,
  parameter int unsigned P_SLOW_STEP_CYC   = 5
)(
  input wire logic              i_mclk,
  input wire logic              i_rst,
  input wire dss_pkg::dss_bus_t i_bus,
  input wire logic [7:0]        o_rdata,
  input wire logic              o_seg_valid,
  input wire dss_pkg::dss_seg_t o_seg,
  input wire logic              i_seg_ready,
  input wire logic              o_loop_running,
  input wire logic              o_name_pending
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic [7:0] len_q;
  logic       bufw_q;
  logic [1:0] zcnt_q;
  logic       wr_len;
  logic       wr_buf;
  assign wr_len = i_bus.wr && (i_bus.addr == ADDR_TEXT_LEN);
  assign wr_buf = i_bus.wr && (i_bus.addr >= ADDR_NAME_BUF_LO) && (i_bus.addr <= ADDR_NAME_BUF_HI);

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      len_q  <= 8'h00;
      bufw_q <= 1'b0;
      zcnt_q <= 2'h0;
    end
    else
    begin
      if (wr_len)
        len_q <= i_bus.wdata;
      // a write that meets the stop belongs to the next session
      if (i_bus.stop)
        bufw_q <= wr_buf;
      else if (wr_buf)
        bufw_q <= 1'b1;
      if (wr_len || (len_q != 8'h00))
        zcnt_q <= 2'h0;
      else if (zcnt_q != 2'h3)
        zcnt_q <= zcnt_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_status_read: assert property (
    i_bus.rd && (i_bus.addr == ADDR_STATUS) |=>
      o_rdata == {4'h0, $past(o_name_pending), $past(o_loop_running), 2'h0})
    else $error("status read does not match flags");
  a_rsvd_read: assert property (
    i_bus.rd && (i_bus.addr == ADDR_RESERVED) |=> o_rdata == 8'h00)
    else $error("reserved byte read not zero");
  a_rdata_holds: assert property (
    !i_bus.rd |=> $stable(o_rdata))
    else $error("read data changed without a read");
  a_seg_holds: assert property (
    o_seg_valid && !i_seg_ready |=> o_seg_valid && $stable(o_seg))
    else $error("segment lost or changed while stalled");
  a_len_starts: assert property (
    wr_len && (i_bus.wdata != 8'h00) |-> ##[1:4] o_loop_running)
    else $error("length write did not start loop");
  a_zero_len_idle: assert property (
    zcnt_q == 2'h3 |-> !o_loop_running)
    else $error("loop running with zero length");
  a_loop_needs_len: assert property (
    $rose(o_loop_running) |-> len_q != 8'h00)
    else $error("loop started with zero length");
  a_pending_set: assert property (
    i_bus.stop && bufw_q |=> o_name_pending)
    else $error("pending not set after stop");
  a_pending_cause: assert property (
    $rose(o_name_pending) |-> $past(i_bus.stop))
    else $error("pending rose without a stop");
  a_first_push: assert property (
    $fell(i_rst) |-> ##[0:2] o_seg_valid)
    else $error("no static segment after reset");
endmodule : dss_scroller_assertions

// ===== tb/dss_seg_sink.sv
// partner model: group assembler taking segments, with optional stalls
`timescale 1ns/1ps

module dss_seg_sink
  import dss_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic              i_stall,
  input  wire logic              i_seg_valid,
  input  wire dss_pkg::dss_seg_t i_seg,
  output logic                   o_seg_ready
);
  logic [63:0] dyn_q[$];
  int          dyn_t[$];
  logic [63:0] last_static = 64'h0;
  int          cyc = 0;

  // stalls half of every eight cycles when asked to
  assign o_seg_ready = !(i_stall && cyc[2]);

  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (!i_rst && i_seg_valid && o_seg_ready)
    begin
      // chars[7] leaves first as the high byte
      if (i_seg.dynamic)
      begin
        dyn_q.push_back(i_seg.chars);
        dyn_t.push_back(cyc);
      end
      else
        last_static <= i_seg.chars;
    end
  end
endmodule : dss_seg_sink

// ===== tb/tb_top.sv
// testbench top: register tests and display sequences of the scroller
`timescale 1ns/1ps

module tb_top;
  import dss_pkg::*;
  logic              i_mclk = 1'b0;
  logic              i_rst  = 1'b1;
  dss_bus_t          bus    = '0;
  logic              stall  = 1'b0;
  logic [7:0]        o_rdata;
  logic              o_seg_valid;
  dss_seg_t          o_seg;
  logic              seg_ready;
  logic              o_loop_running;
  logic              o_name_pending;
  int                err_count   = 0;
  int                comparisons = 0;
  logic [7:0]        cfg_a [5] = '{ADDR_STATIC_IVL, ADDR_DISPLAY_STYLE, ADDR_SEG_HOLD,
                                   ADDR_SCROLL_RATE, ADDR_TEXT_LEN};
  logic [7:0]        cfg_v [5] = '{8'h5a, 8'h03, 8'ha5, 8'h01, 8'h50};

  always #5 i_mclk = ~i_mclk;

  dss_scroller #(.P_HOLD_UNIT_CYC(4), .P_STATIC_UNIT_CYC(10), .P_FAST_STEP_CYC(3),
    .P_SLOW_STEP_CYC(5)) dss_scroller_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_bus(bus),
    .o_rdata(o_rdata), .o_seg_valid(o_seg_valid), .o_seg(o_seg), .i_seg_ready(seg_ready),
    .o_loop_running(o_loop_running), .o_name_pending(o_name_pending));
  dss_seg_sink dss_seg_sink_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_stall(stall),
    .i_seg_valid(o_seg_valid), .i_seg(o_seg), .o_seg_ready(seg_ready));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic stp = 1'b0);
    bus <= '{wr: !stp, rd: 1'b0, stop: stp, addr: a, wdata: d};
    @(posedge i_mclk);
    bus <= '0;
    @(posedge i_mclk);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    bus <= '{wr: 1'b0, rd: 1'b1, stop: 1'b0, addr: a, wdata: 8'h00};
    @(posedge i_mclk);
    bus <= '0;
    @(posedge i_mclk);
    chk(what, {56'h0, exp}, {56'h0, o_rdata});
  endtask : rd_chk

  task automatic wait_lvl(input logic pend, input logic lvl, input int lim);
    int n;
    n = 0;
    while (((pend ? o_name_pending : o_loop_running) !== lvl) && n < lim)
    begin
      @(posedge i_mclk);
      n++;
    end
    chk(pend ? "pending_wait" : "loop_wait", 64'(lvl), 64'(n < lim ? lvl : !lvl));
  endtask : wait_lvl

  function automatic logic [63:0] seg8(input string s);
    logic [63:0] r;
    for (int i = 0; i < 8; i++)
      r[63-8*i -: 8] = s[i];
    return r;
  endfunction : seg8

  task automatic run(input logic [1:0] st, input string txt, input logic stl);
    wr(ADDR_TEXT_LEN, 8'h00);
    for (int i = 0; i < txt.len(); i++)
      wr(ADDR_TEXT_FIRST + 8'(i), txt[i]);
    wr(ADDR_DISPLAY_STYLE, {6'h00, st});
    stall <= stl;
    dss_seg_sink_inst.dyn_q.delete();
    dss_seg_sink_inst.dyn_t.delete();
    wr(ADDR_TEXT_LEN, 8'(txt.len()));
    wait_lvl(1'b0, 1'b1, 10);
    wait_lvl(1'b0, 1'b0, 3000);
    stall <= 1'b0;
  endtask : run

  task automatic gaps(input int lo);
    int g;
    for (int i = 1; i < dss_seg_sink_inst.dyn_t.size(); i++)
    begin
      g = dss_seg_sink_inst.dyn_t[i] - dss_seg_sink_inst.dyn_t[i-1];
      comparisons++;
      if (g < lo || g > lo + 2)
      begin
        err_count++;
        $display("Error step_gap expected %0d seen %0d", lo, g);
      end
    end
  endtask : gaps

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    int n;
    string s;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    for (int i = 0; i < 5; i++)
      rd_chk("reset_value", cfg_a[i], 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wr(cfg_a[i], cfg_v[i]);
      rd_chk("readback", cfg_a[i], cfg_v[i]);
    end
    wr(ADDR_TEXT_LEN, 8'h51);
    rd_chk("len_clamp", ADDR_TEXT_LEN, 8'h50);
    wr(ADDR_TEXT_LEN, 8'h00);
    repeat (10) @(posedge i_mclk);
    rd_chk("status_idle", ADDR_STATUS, 8'h00);
    rd_chk("reserved", ADDR_RESERVED, 8'h00);
    rd_chk("unmapped", 8'h00, 8'h00);
    s = "STATNAME";
    for (int i = 0; i < 8; i++)
      wr(ADDR_NAME_ACT_LO + 8'(i), s[i]);
    wr(8'h00, 8'h00, 1'b1);
    wr(ADDR_STATIC_IVL, ONCE_IVL);
    wr(ADDR_SEG_HOLD, 8'h03);
    wr(ADDR_SCROLL_RATE, 8'h00);
    run(STYLE_BLOCK, "ABCDEFGHIJKLMNOP", 1'b0);
    chk("block_count", 64'd2, 64'(dss_seg_sink_inst.dyn_q.size()));
    chk("block_seg0", seg8("ABCDEFGH"), dss_seg_sink_inst.dyn_q[0]);
    chk("block_seg1", seg8("IJKLMNOP"), dss_seg_sink_inst.dyn_q[1]);
    gaps(12);
    chk("static_name", seg8("STATNAME"), dss_seg_sink_inst.last_static);
    run(STYLE_SHIFT, "ABCDEFGHIJ", 1'b0);
    chk("shift_count", 64'd3, 64'(dss_seg_sink_inst.dyn_q.size()));
    chk("shift_seg2", seg8("CDEFGHIJ"), dss_seg_sink_inst.dyn_q[2]);
    gaps(3);
    wr(ADDR_SCROLL_RATE, 8'h01);
    run(STYLE_PAD_SHIFT, "AB", 1'b0);
    chk("pad_seg0", seg8("       A"), dss_seg_sink_inst.dyn_q[0]);
    chk("pad_seg1", seg8("      AB"), dss_seg_sink_inst.dyn_q[1]);
    gaps(5);
    run(STYLE_WORD, "ABC DEFG HIJ", 1'b1);
    chk("word_seg0", seg8("ABC DEFG"), dss_seg_sink_inst.dyn_q[0]);
    chk("word_seg1", {40'h0, seg8("HIJ     ") >> 40}, {40'h0, dss_seg_sink_inst.dyn_q[1] >> 40});
    n = dss_seg_sink_inst.dyn_q.size();
    repeat (300) @(posedge i_mclk);
    chk("once_count", 64'(n), 64'(dss_seg_sink_inst.dyn_q.size()));
    rd_chk("status_once", ADDR_STATUS, 8'h00);
    s = "BUFNAME1";
    for (int i = 0; i < 8; i++)
      wr(ADDR_NAME_BUF_LO + 8'(i), s[i]);
    wr(8'h00, 8'h00, 1'b1);
    wait_lvl(1'b1, 1'b1, 4);
    wait_lvl(1'b1, 1'b0, 500);
    repeat (20) @(posedge i_mclk);
    chk("copied_name", seg8("BUFNAME1"), dss_seg_sink_inst.last_static);
    rd_chk("active_byte", ADDR_NAME_ACT_LO, 8'h42);
    report_and_stop();
  end

  initial
  begin
    #1000000;
    err_count++;
    $display("Error watchdog expected done seen timeout");
    report_and_stop();
  end
endmodule : tb_top

bind dss_scroller dss_scroller_assertions #(.P_HOLD_UNIT_CYC(P_HOLD_UNIT_CYC),
  .P_STATIC_UNIT_CYC(P_STATIC_UNIT_CYC), .P_FAST_STEP_CYC(P_FAST_STEP_CYC),
  .P_SLOW_STEP_CYC(P_SLOW_STEP_CYC)) dss_scroller_assertions_inst (.i_mclk(i_mclk),
  .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata), .o_seg_valid(o_seg_valid), .o_seg(o_seg),
  .i_seg_ready(i_seg_ready), .o_loop_running(o_loop_running),
  .o_name_pending(o_name_pending));
